// file: core/mdsr_consts.vh
/*
 * Constants of the motor driver status register: address, field positions, reset values.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef MDSR_CONSTS_VH
`define MDSR_CONSTS_VH

`define MDSR_ADDR_WIDTH 5
`define MDSR_STATUS_ADDR 5'h02
`define MDSR_OC_MSB 15
`define MDSR_OC_LSB 8
`define MDSR_OPEN_A_BIT 7
`define MDSR_OPEN_B_BIT 6
`define MDSR_UPPER_BIT 3
`define MDSR_LOWER_A_BIT 2
`define MDSR_LOWER_B_BIT 1
`define MDSR_PARITY_BIT 0
`define MDSR_OC_RESET 8'h00
`define MDSR_OL_RESET 2'h0
`define MDSR_CV_RESET 3'h0
`define MDSR_CV_WIDTH 10

`endif

// file: core/mdsr_status.v
/*
 * Motor driver status register: sticky overcurrent and open-load flags,
 * coil-voltage window flags, summary flags and the read port with parity.
 * Assumes the serial interface presents a read address and takes data the
 * following cycle; event inputs are synchronous one-cycle or level strobes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mdsr_consts.vh"

// Contract
// - eight overcurrent flags in bits 15..8: A1H,A1L,A2H,A2L,B1H,B1L,B2H,B2L
// - overcurrent flags stay set until the overcurrent summary is cleared
// - phase A open-load flag sets when reference missed within delay
// - phase B open-load flag sets when reference missed within delay
// - clearing open-load summary clears both open-load flags; the only other clear path is srst
// - coil-voltage flags update only while measurement is enabled, else hold
// - upper flag set when sample exceeds upper threshold, cleared otherwise
// - lower-a flag set when sample below lower threshold a, cleared otherwise
// - lower-b flag set when sample below lower threshold b, cleared otherwise
// - register at address 0x02, read-only, reset zero, bits 5 and 4 reserved
// - overcurrent summary sets as soon as any overcurrent flag sets
// - open-load summary sets as soon as either open-load flag sets
module mdsr_status #(
	parameter CV_WIDTH = `MDSR_CV_WIDTH
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// overcurrent events, bit 7 = a1 high ... bit 0 = b2 low
	input wire [7:0] overcurrent_event,
	// open-load timeouts from the current regulators
	input wire open_load_phase_a_event,
	input wire open_load_phase_b_event,
	// coil-voltage sampling
	input wire coil_measure_enable,
	input wire coil_sample_valid,
	input wire [CV_WIDTH-1:0] coil_sample,
	input wire [CV_WIDTH-1:0] coil_upper_threshold,
	input wire [CV_WIDTH-1:0] coil_lower_threshold_a,
	input wire [CV_WIDTH-1:0] coil_lower_threshold_b,
	// summary clears from the global status register
	input wire overcurrent_summary_clear,
	input wire open_load_summary_clear,
	// summary flags toward the global status register
	output wire overcurrent_summary,
	output wire open_load_summary,
	// register read port of the serial interface
	input wire rd_en,
	input wire [`MDSR_ADDR_WIDTH-1:0] rd_addr,
	output reg [15:0] rd_data,
	output reg rd_hit,
	// live register value
	output wire [15:0] motor_driver_status
);

	reg [7:0] oc_reg;
	reg [7:0] oc_next;
	reg [1:0] ol_reg;
	reg [1:0] ol_next;
	reg [2:0] cv_reg;
	reg [2:0] cv_next;
	reg oc_sum_reg;
	reg ol_sum_reg;
	wire [15:0] status_word;
	wire cv_update;

	// event set wins over a clear in the same cycle
	always @* begin
		oc_next = oc_reg;
		if (overcurrent_summary_clear) begin
			oc_next = 8'h00;
		end
		oc_next = oc_next | overcurrent_event;
	end

	always @* begin
		ol_next = ol_reg;
		if (open_load_summary_clear) begin
			ol_next = 2'h0;
		end
		ol_next[1] = ol_next[1] | open_load_phase_a_event;
		ol_next[0] = ol_next[0] | open_load_phase_b_event;
	end

	assign cv_update = coil_measure_enable & coil_sample_valid;

	always @* begin
		cv_next = cv_reg;
		if (cv_update) begin
			cv_next[2] = (coil_sample > coil_upper_threshold);
			cv_next[1] = (coil_sample < coil_lower_threshold_a);
			cv_next[0] = (coil_sample < coil_lower_threshold_b);
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			oc_reg <= `MDSR_OC_RESET;
			ol_reg <= `MDSR_OL_RESET;
			cv_reg <= `MDSR_CV_RESET;
			oc_sum_reg <= 1'b0;
			ol_sum_reg <= 1'b0;
		end else begin
			oc_reg <= oc_next;
			ol_reg <= ol_next;
			cv_reg <= cv_next;
			// summary follows the same set-wins ordering as the flags
			oc_sum_reg <= (oc_sum_reg & ~overcurrent_summary_clear) | (|overcurrent_event);
			ol_sum_reg <= (ol_sum_reg & ~open_load_summary_clear) |
				open_load_phase_a_event | open_load_phase_b_event;
		end
	end

	assign overcurrent_summary = oc_sum_reg;
	assign open_load_summary = ol_sum_reg;

	// reserved bits 5 and 4 read zero; parity slot zero before insertion
	assign status_word = {oc_reg, ol_reg, 2'b00, cv_reg, 1'b0};
	assign motor_driver_status = status_word;

	// even parity: bit 0 makes the whole word an even count of ones
	always @(posedge clk) begin
		if (srst) begin
			rd_data <= 16'h0000;
			rd_hit <= 1'b0;
		end else begin
			rd_hit <= rd_en && (rd_addr == `MDSR_STATUS_ADDR);
			if (rd_en && (rd_addr == `MDSR_STATUS_ADDR)) begin
				rd_data <= {status_word[15:1], ^status_word[15:1]};
			end else if (rd_en) begin
				rd_data <= 16'h0000;
			end
		end
	end

endmodule
`default_nettype wire

// file: verification/mdsr_host.sv
/* host read model; assumes the mdsr_status read port */
`timescale 1ns/1ps
`default_nettype none
module mdsr_host(input wire logic clk, output logic rd_en = 0, output logic [4:0] rd_addr = 0);
task rd(input logic [4:0] a);
	@(posedge clk) {rd_en, rd_addr} <= {1'b1, a};
	@(posedge clk) rd_en <= 0;
endtask
endmodule
`default_nettype wire

// file: verification/mdsr_status_asserts.sv
/* checker on mdsr_status ports; bound to the design module below */
`timescale 1ns/1ps
`default_nettype none
module mdsr_chk(
	input wire logic clk, srst, rd_en, rd_hit, overcurrent_summary_clear, overcurrent_summary,
	input wire logic open_load_phase_a_event, open_load_summary, coil_measure_enable,
	input wire logic coil_sample_valid,
	input wire logic [7:0] overcurrent_event,
	input wire logic [4:0] rd_addr,
	input wire logic [9:0] coil_sample, coil_upper_threshold,
	input wire logic [15:0] rd_data, motor_driver_status);
wire [15:0] s = motor_driver_status;
wire [7:0] e = overcurrent_event;
wire c = coil_measure_enable && coil_sample_valid;
default clocking @(posedge clk); endclocking
default disable iff (srst);
oc_set_a: assert property (|e |=> (s[15:8] & $past(e)) == $past(e))
	else $error("oc flag");
oc_sum_a: assert property (|e |=> overcurrent_summary)
	else $error("oc summary");
oc_clear_a: assert property (overcurrent_summary_clear && !e |=> !s[15:8])
	else $error("oc clear");
ol_set_a: assert property (open_load_phase_a_event |=> s[7] && open_load_summary)
	else $error("ol flag");
cv_hold_a: assert property (!c |=> $stable(s[3:1]))
	else $error("cv hold");
cv_upper_a: assert property (c |=> s[3] == ($past(coil_sample) > $past(coil_upper_threshold)))
	else $error("cv upper");
rd_word_a: assert property (rd_en && rd_addr == 5'h02 |=> rd_hit && rd_data == ($past(s) | ^$past(s)))
	else $error("read word");
rd_miss_a: assert property (rd_en && rd_addr != 5'h02 |=> !rd_hit && !rd_data)
	else $error("read miss");
endmodule
bind mdsr_status mdsr_chk mdsr_chk_inst(.*);
`default_nettype wire

// file: verification/test_mdsr_status.sv
/* bench: table of strobes, each followed by a read; assumes one 50 MHz clock */
`timescale 1ns/1ps
`default_nettype none
module test_mdsr_status;
logic clk = 0, srst = 1;
logic [23:0] p = 0;
wire logic rd_en, rd_hit;
wire logic [4:0] rd_addr;
wire logic [15:0] rd_data;
int failures = 0, check_count = 0, cyc = 0;
// addr, {oc events, ol a b, clears, enable, valid, sample}, {hit, word}
logic [51:0] t[11] = '{52'h02_000000_10000, 52'h02_810000_18100, 52'h02_400000_1c101,
	52'h02_002000_10000, 52'h02_00c000_100c0, 52'h02_001000_10000,
	52'h02_000e01_10009, 52'h02_000cff_10005, 52'h02_00047f_10005,
	52'h02_000c7f_10006, 52'h03_000000_00000};
always #10 clk = ~clk;
mdsr_host mdsr_host_inst(.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr));
mdsr_status mdsr_status_inst(.clk(clk), .srst(srst), .overcurrent_event(p[23:16]),
	.open_load_phase_a_event(p[15]), .open_load_phase_b_event(p[14]), .coil_sample(p[9:0]),
	.overcurrent_summary_clear(p[13]), .open_load_summary_clear(p[12]), .rd_hit(rd_hit),
	.coil_measure_enable(p[11]), .coil_sample_valid(p[10]), .coil_upper_threshold(10'h200),
	.coil_lower_threshold_a(10'h100), .coil_lower_threshold_b(10'h080), .rd_en(rd_en),
	.rd_addr(rd_addr), .rd_data(rd_data), .overcurrent_summary(), .open_load_summary(),
	.motor_driver_status());
task chk(input logic [19:0] s, x);
	check_count++;
	if (s !== x) begin
		failures++;
		$display("[ERR] %0t got %h want %h", $time, s, x);
	end
endtask
task end_sim(input int bad);
	failures += bad;
	$display("%0d checks, %0d failures", check_count, failures);
	if (failures == 0 && check_count > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
always @(posedge clk) if (cyc++ == 2000) end_sim(1);
initial begin
	repeat (20) @(posedge clk);
	srst <= 0;
	foreach (t[i]) begin
		@(posedge clk) p <= t[i][43:20];
		@(posedge clk) p <= p & 24'h000800;
		mdsr_host_inst.rd(t[i][48:44]);
		#1 chk({3'h0, rd_hit, rd_data}, t[i][19:0]);
	end
	end_sim(0);
end
endmodule
`default_nettype wire
